/* File: hdl/lmrb_top.sv */
// mode register bank: latency, drive strength, temperature and identity registers
//
// How it works
// R1: latency code picks read/write latency pair
// R2: latency register at address 02h, bits 3:0
// R3: drive register at 03h, bits 3:0
// R4: drive code picks output impedance
// R5: temperature register 04h read-only, rate plus flag
// R6: codes 000b/111b mark temperature limits exceeded
// R7: rate codes give refresh multipliers
// R8: flag set when rate changed since read
// R9: reading temperature register clears the flag
// R10: flag is zero after power-up
// R11: rate bit 2 set above 85 C
// R12: controller derates core timings when told
// R13: controller treats 000b/111b as out of range
// R14: maker code read-only at 05h
// R15: revision codes read-only at 06h, 07h
// R16: configuration at 08h: type, density, width
// R17: writes to read-only registers are ignored
`timescale 1ns/1ns
`include "lmrb_map.svh"
module lmrb_top #(
  parameter lmrb_pkg::lmrb_byte_t MAKER_ID  = 8'h5a,
  parameter lmrb_pkg::lmrb_byte_t REV_ONE   = 8'h11,
  parameter lmrb_pkg::lmrb_byte_t REV_TWO   = 8'h22,
  parameter logic [3:0]           DENSITY   = 4'h4,
  parameter logic [1:0]           IO_WIDTH  = 2'h1,
  parameter int                   LOW_LIMIT_C  = -30,
  parameter int                   RATE_4X_C    = 20,
  parameter int                   RATE_2X_C    = 50,
  parameter int                   NODERATE_C   = 95,
  parameter int                   HIGH_LIMIT_C = 105
) (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_sys_rst,
  // mode register commands
  input  wire logic                 i_mrw_req,
  input  wire logic                 i_mrr_req,
  input  wire lmrb_pkg::lmrb_byte_t i_ma,
  input  wire lmrb_pkg::lmrb_byte_t i_op,
  // read answer
  output logic                      o_rd_valid,
  output lmrb_pkg::lmrb_byte_t      o_rd_data,
  output logic                      o_rd_busy,
  // sensor
  input  wire logic [7:0]           i_die_temp,
  // configuration to the core
  output logic [3:0]                o_read_latency,
  output logic [2:0]                o_write_latency,
  output logic [3:0]                o_drive_strength,
  output logic [11:0]               o_drive_ohm_tenths,
  output lmrb_pkg::lmrb_rate_t      o_refresh_rate,
  output logic                      o_temperature_update_flag
);
  import lmrb_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  logic [3:0]  latency_configuration;
  logic [3:0]  io_drive_config;
  lmrb_rate_t  rate_now;
  lmrb_rate_t  rate_seen;
  logic        rate_changed;
  lmrb_rdst_t  rd_state;
  lmrb_rdst_t  next_rd_state;
  logic [3:0]  rd_cnt;
  lmrb_byte_t  rd_hold;
  lmrb_byte_t  rd_mux;
  lmrb_byte_t  device_temperature;
  lmrb_byte_t  basic_configuration;
  logic        wr_lat;
  logic        wr_drv;
  logic        rd_take;
  logic        rd_temp;
  logic        rd_done;
  logic [3:0]  new_lat;
  logic [3:0]  new_drv;
  logic        lat_legal;
  logic [3:0]  dec_rl;
  logic [2:0]  dec_wl;
  logic        drv_legal;
  logic [11:0] dec_ohm;
  // next values
  logic        next_flag;
  logic [3:0]  next_rd_cnt;
  logic        next_rd_valid;
  lmrb_byte_t  next_rd_data;
  logic        next_rd_busy;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic hit(input lmrb_byte_t ma, input lmrb_byte_t reg_ma);
    hit = (ma == reg_ma);
  endfunction

  // ****************************************
  // decoders and sensor
  // ****************************************
  assign new_lat = i_op[`LMRB_LAT_MSB:`LMRB_LAT_LSB]; //R2
  assign new_drv = i_op[`LMRB_DRV_MSB:`LMRB_DRV_LSB]; //R3

  lmrb_latdec u_latdec (
    .i_lat_code       (new_lat),
    .i_drv_code       (new_drv),
    .o_lat_legal      (lat_legal),
    .o_read_latency   (dec_rl),
    .o_write_latency  (dec_wl),
    .o_drv_legal      (drv_legal),
    .o_drv_ohm_tenths (dec_ohm)
  );

  lmrb_tempsens #(
    .LOW_LIMIT_C  (LOW_LIMIT_C),
    .RATE_4X_C    (RATE_4X_C),
    .RATE_2X_C    (RATE_2X_C),
    .NODERATE_C   (NODERATE_C),
    .HIGH_LIMIT_C (HIGH_LIMIT_C)
  ) u_tempsens (
    .i_clk      (i_clk),
    .i_sys_rst  (i_sys_rst),
    .i_die_temp (i_die_temp),
    .o_rate     (rate_now)
  );

  // ****************************************
  // command decode
  // ****************************************
  // reserved codes leave the field as it was, so a bad write cannot
  // push the core into an undefined latency or impedance
  assign wr_lat  = i_mrw_req && hit(i_ma, `LMRB_MA_LATENCY) && lat_legal; //R2 R17
  assign wr_drv  = i_mrw_req && hit(i_ma, `LMRB_MA_IODRIVE) && drv_legal; //R3 R17
  // a read in the same cycle as a write, or while one waits, is dropped
  assign rd_take = i_mrr_req && !i_mrw_req && (rd_state == LMRB_RD_IDLE);
  assign rd_temp = rd_take && hit(i_ma, `LMRB_MA_TEMP);
  assign rd_done = (rd_state == LMRB_RD_WAIT) && (rd_cnt == 4'h1);
  assign rate_changed = (rate_now != rate_seen);

  // ****************************************
  // read image of each readable register
  // ****************************************
  always_comb begin
    device_temperature = `LMRB_ZERO8; //R5
    device_temperature[`LMRB_RATE_MSB:`LMRB_RATE_LSB] = o_refresh_rate; //R5
    device_temperature[`LMRB_TUF_BIT] = o_temperature_update_flag; //R5
  end

  always_comb begin
    basic_configuration = `LMRB_ZERO8;
    basic_configuration[`LMRB_TYPE_MSB:`LMRB_TYPE_LSB] = `LMRB_TYPE_NVM; //R16
    basic_configuration[`LMRB_DENS_MSB:`LMRB_DENS_LSB] = DENSITY; //R16
    basic_configuration[`LMRB_WID_MSB:`LMRB_WID_LSB]   = IO_WIDTH; //R16
  end

  // write-only and unmapped addresses read back as zero
  always_comb begin
    unique case (i_ma)
      `LMRB_MA_TEMP:     rd_mux = device_temperature; //R5
      `LMRB_MA_MAKER:    rd_mux = MAKER_ID; //R14
      `LMRB_MA_REV_ONE:  rd_mux = REV_ONE; //R15
      `LMRB_MA_REV_TWO:  rd_mux = REV_TWO; //R15
      `LMRB_MA_BASICCFG: rd_mux = basic_configuration; //R16
      default:           rd_mux = `LMRB_ZERO8;
    endcase
  end

  // ****************************************
  // writable registers
  // ****************************************
  // writes to 04h..08h match neither strobe and change nothing
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      latency_configuration <= `LMRB_LAT_RST;
      o_read_latency        <= `LMRB_RL_RST;
      o_write_latency       <= `LMRB_WL_RST;
    end else if (wr_lat) begin
      latency_configuration <= new_lat; //R2
      o_read_latency        <= dec_rl; //R1
      o_write_latency       <= dec_wl; //R1
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      io_drive_config    <= `LMRB_DRV_RST;
      o_drive_ohm_tenths <= `LMRB_OHM_RST;
    end else if (wr_drv) begin
      io_drive_config    <= new_drv; //R3
      o_drive_ohm_tenths <= dec_ohm; //R4
    end
  end

  assign o_drive_strength = io_drive_config;

  // ****************************************
  // temperature register and update flag
  // ****************************************
  // rate_seen is the last code loaded into the register; a change sets
  // the flag even in the cycle of a read, so no change is ever lost
  assign next_flag = rate_changed ? 1'b1 : (rd_temp ? 1'b0 : o_temperature_update_flag); //R8 R9

  // code and flag move on the same edge, so a reader never
  // sees a new code with a stale flag
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_refresh_rate <= `LMRB_RATE_RST;
      rate_seen      <= `LMRB_RATE_RST;
    end else begin
      o_refresh_rate <= rate_now; //R7
      rate_seen      <= rate_now;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_temperature_update_flag <= 1'b0; //R10
    end else begin
      o_temperature_update_flag <= next_flag; //R8
    end
  end

  // ****************************************
  // read sequencer
  // ****************************************
  always_comb begin
    next_rd_state = rd_state;
    unique case (rd_state)
      LMRB_RD_IDLE: begin
        if (rd_take) begin
          next_rd_state = LMRB_RD_WAIT;
        end
      end
      LMRB_RD_WAIT: begin
        if (rd_done) begin
          next_rd_state = LMRB_RD_IDLE;
        end
      end
      default: next_rd_state = LMRB_RD_IDLE;
    endcase
  end

  // the registered answer stage uses up one latency cycle, so the
  // count starts one short; reads are only taken while idle, so a
  // count in flight is never restarted
  assign next_rd_cnt = rd_take ? (o_read_latency - `LMRB_ANS_STAGES) : //R1
                       ((rd_state == LMRB_RD_WAIT) ? (rd_cnt - 4'h1) : rd_cnt);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_state <= LMRB_RD_IDLE;
    end else begin
      rd_state <= next_rd_state;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_cnt  <= 4'h0;
      rd_hold <= `LMRB_ZERO8;
    end else begin
      rd_cnt <= next_rd_cnt; //R1
      if (rd_take) begin
        rd_hold <= rd_mux;
      end
    end
  end

  // ****************************************
  // read answer, read_latency cycles after the request cycle
  // ****************************************
  // data is zero outside its valid cycle, so a late sampler cannot
  // take a stale byte for an answer
  assign next_rd_valid = rd_done;
  assign next_rd_data  = rd_done ? rd_hold : `LMRB_ZERO8;
  assign next_rd_busy  = (next_rd_state == LMRB_RD_WAIT);

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= next_rd_valid; //R1
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rd_data <= `LMRB_ZERO8;
    end else begin
      o_rd_data <= next_rd_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      o_rd_busy <= 1'b0;
    end else begin
      o_rd_busy <= next_rd_busy;
    end
  end
endmodule // lmrb_top

/* File: hdl/lmrb_map.svh */
// mode register addresses, field positions and reset values of the mode register bank
`ifndef LMRB_MAP_SVH
`define LMRB_MAP_SVH

// ****************************************
// addresses
// ****************************************
`define LMRB_MA_LATENCY   8'h02
`define LMRB_MA_IODRIVE   8'h03
`define LMRB_MA_TEMP      8'h04
`define LMRB_MA_MAKER     8'h05
`define LMRB_MA_REV_ONE   8'h06
`define LMRB_MA_REV_TWO   8'h07
`define LMRB_MA_BASICCFG  8'h08

// ****************************************
// fields
// ****************************************
`define LMRB_LAT_MSB      3
`define LMRB_LAT_LSB      0
`define LMRB_DRV_MSB      3
`define LMRB_DRV_LSB      0
`define LMRB_RATE_MSB     2
`define LMRB_RATE_LSB     0
`define LMRB_TUF_BIT      7
`define LMRB_HOT_BIT      2
`define LMRB_TYPE_MSB     1
`define LMRB_TYPE_LSB     0
`define LMRB_DENS_MSB     5
`define LMRB_DENS_LSB     2
`define LMRB_WID_MSB      7
`define LMRB_WID_LSB      6

// ****************************************
// codes and reset values
// ****************************************
`define LMRB_LAT_RST      4'h1
`define LMRB_DRV_RST      4'h2
`define LMRB_RL_RST       4'h3
`define LMRB_WL_RST       3'h1
`define LMRB_OHM_RST      12'h190
`define LMRB_RATE_RST     3'h3
`define LMRB_RATE_LOW     3'h0
`define LMRB_RATE_4X      3'h1
`define LMRB_RATE_2X      3'h2
`define LMRB_RATE_1X      3'h3
`define LMRB_RATE_QNODER  3'h5
`define LMRB_RATE_QDER    3'h6
`define LMRB_RATE_HIGH    3'h7
`define LMRB_TYPE_NVM     2'h2
`define LMRB_ZERO8        8'h00
`define LMRB_HOT_LIMIT_C  85
`define LMRB_ANS_STAGES   4'h1

`endif

/* File: hdl/lmrb_pkg.sv */
// types shared by the mode register bank
package lmrb_pkg;
  typedef enum logic [1:0] {
    LMRB_RD_IDLE = 2'b01,
    LMRB_RD_WAIT = 2'b10
  } lmrb_rdst_t;
  typedef logic [7:0] lmrb_byte_t;
  typedef logic [2:0] lmrb_rate_t;
endpackage

/* File: hdl/lmrb_latdec.sv */
// decoders for the latency and drive strength codes
`timescale 1ns/1ns
`include "lmrb_map.svh"
module lmrb_latdec (
  // codes in
  input  wire logic [3:0]  i_lat_code,
  input  wire logic [3:0]  i_drv_code,
  // decoded
  output logic             o_lat_legal,
  output logic [3:0]       o_read_latency,
  output logic [2:0]       o_write_latency,
  output logic             o_drv_legal,
  output logic [11:0]      o_drv_ohm_tenths
);
  // ****************************************
  // latency pairs
  // ****************************************
  always_comb begin
    o_lat_legal     = 1'b1;
    o_read_latency  = `LMRB_RL_RST;
    o_write_latency = `LMRB_WL_RST;
    unique case (i_lat_code)
      4'h1: begin o_read_latency = 4'h3; o_write_latency = 3'h1; end //R1
      4'h2: begin o_read_latency = 4'h4; o_write_latency = 3'h2; end //R1
      4'h3: begin o_read_latency = 4'h5; o_write_latency = 3'h2; end //R1
      4'h4: begin o_read_latency = 4'h6; o_write_latency = 3'h3; end //R1
      4'h5: begin o_read_latency = 4'h7; o_write_latency = 3'h4; end //R1
      4'h6: begin o_read_latency = 4'h8; o_write_latency = 3'h4; end //R1
      default: o_lat_legal = 1'b0; //R1
    endcase
  end

  // ****************************************
  // drive strength in tenths of an ohm
  // ****************************************
  always_comb begin
    o_drv_legal      = 1'b1;
    o_drv_ohm_tenths = `LMRB_OHM_RST;
    unique case (i_drv_code)
      4'h1: o_drv_ohm_tenths = 12'h157; //R4
      4'h2: o_drv_ohm_tenths = 12'h190; //R4
      4'h3: o_drv_ohm_tenths = 12'h1e0; //R4
      4'h4: o_drv_ohm_tenths = 12'h258; //R4
      4'h6: o_drv_ohm_tenths = 12'h320; //R4
      4'h7: o_drv_ohm_tenths = 12'h4b0; //R4
      default: o_drv_legal = 1'b0; //R4
    endcase
  end
endmodule // lmrb_latdec

/* File: hdl/lmrb_tempsens.sv */
// die temperature synchroniser and refresh-rate quantiser
`timescale 1ns/1ns
`include "lmrb_map.svh"
module lmrb_tempsens #(
  parameter int LOW_LIMIT_C  = -30,
  parameter int RATE_4X_C    = 20,
  parameter int RATE_2X_C    = 50,
  parameter int NODERATE_C   = 95,
  parameter int HIGH_LIMIT_C = 105
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  // sensor
  input  wire logic [7:0]  i_die_temp,
  // rate
  output lmrb_pkg::lmrb_rate_t o_rate
);
  import lmrb_pkg::*;
  logic [7:0]  sync_a;
  logic [7:0]  sync_b;
  logic [7:0]  last_b;
  logic        stable;
  logic [1:0]  fill;
  int          temp_c;
  lmrb_rate_t  next_rate;

  // ****************************************
  // two-flop sync; a word is taken only when two samples agree
  // ****************************************
  always_ff @(posedge i_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      sync_a <= `LMRB_ZERO8;
      sync_b <= `LMRB_ZERO8;
      last_b <= `LMRB_ZERO8;
      fill   <= 2'h0;
      o_rate <= `LMRB_RATE_RST;
    end else begin
      fill   <= {fill[0], 1'b1};
      sync_a <= i_die_temp;
      sync_b <= sync_a;
      last_b <= sync_b;
      if (stable) begin
        o_rate <= next_rate;
      end
    end
  end

  // reset zeros would read as 0 C; no code is taken until real samples fill the chain
  assign stable = (sync_b == last_b) && fill[1];
  assign temp_c = int'($signed(last_b));

  // ****************************************
  // quantiser, every code above the hot limit has bit 2 set
  // ****************************************
  always_comb begin
    if (temp_c < LOW_LIMIT_C) begin
      next_rate = `LMRB_RATE_LOW; //R6
    end else if (temp_c <= RATE_4X_C) begin
      next_rate = `LMRB_RATE_4X;
    end else if (temp_c <= RATE_2X_C) begin
      next_rate = `LMRB_RATE_2X;
    end else if (temp_c <= `LMRB_HOT_LIMIT_C) begin
      next_rate = `LMRB_RATE_1X; //R11
    end else if (temp_c <= NODERATE_C) begin
      next_rate = `LMRB_RATE_QNODER; //R11
    end else if (temp_c <= HIGH_LIMIT_C) begin
      next_rate = `LMRB_RATE_QDER; //R11
    end else begin
      next_rate = `LMRB_RATE_HIGH; //R6
    end
  end
endmodule // lmrb_tempsens

/* File: sim/lmrb_checker.sv */
// port assertions for the mode register bank
`timescale 1ns/1ns
`include "lmrb_map.svh"
module lmrb_checker (
  // clock and reset
  input wire logic                 i_clk,
  input wire logic                 i_sys_rst,
  // commands
  input wire logic                 i_mrw_req,
  input wire logic                 i_mrr_req,
  input wire lmrb_pkg::lmrb_byte_t i_ma,
  input wire lmrb_pkg::lmrb_byte_t i_op,
  // answers
  input wire logic                 o_rd_valid,
  input wire lmrb_pkg::lmrb_byte_t o_rd_data,
  input wire logic                 o_rd_busy,
  input wire logic [3:0]           o_read_latency,
  input wire logic [2:0]           o_write_latency,
  input wire logic [3:0]           o_drive_strength,
  input wire lmrb_pkg::lmrb_rate_t o_refresh_rate,
  input wire logic                 o_temperature_update_flag
);
  import lmrb_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  wire       rd_tmp = i_mrr_req && !i_mrw_req && !o_rd_busy && i_ma == `LMRB_MA_TEMP;
  wire       lat_wr = i_mrw_req && i_ma == `LMRB_MA_LATENCY;
  wire       drv_wr = i_mrw_req && i_ma == `LMRB_MA_IODRIVE;
  wire [3:0] op_lo  = i_op[3:0];
  wire       drv_ok = op_lo != 4'h0 && op_lo != 4'h5 && op_lo < 4'h8;
  lat_code_a: assert property (lat_wr && op_lo == 4'h4 |=> o_read_latency == 4'h6 && o_write_latency == 3'h3)
    else $error("latency code four not applied");
  lat_keep_a: assert property (lat_wr && (op_lo == 4'h0 || op_lo > 4'h6) |=> $stable(o_read_latency))
    else $error("reserved latency code changed latency");
  drv_code_a: assert property (drv_wr && drv_ok |=> o_drive_strength == $past(op_lo))
    else $error("drive code not stored");
  drv_keep_a: assert property (drv_wr && !drv_ok |=> $stable(o_drive_strength))
    else $error("reserved drive code changed drive");
  ro_ignore_a: assert property (i_mrw_req && i_ma >= `LMRB_MA_TEMP && i_ma <= `LMRB_MA_BASICCFG
    |=> $stable(o_read_latency) && $stable(o_drive_strength) && $stable(o_write_latency))
    else $error("read-only write changed state");
  flag_set_a: assert property ($changed(o_refresh_rate) |-> o_temperature_update_flag)
    else $error("rate change without flag");
  flag_hold_a: assert property (o_temperature_update_flag && !rd_tmp |=> o_temperature_update_flag)
    else $error("flag lost without read");
  flag_clr_a: assert property (rd_tmp ##1 $stable(o_refresh_rate) |-> !o_temperature_update_flag)
    else $error("flag not cleared by read");
  rd_image_a: assert property (rd_tmp && o_read_latency == 4'h3 |-> ##3 o_rd_valid && o_rd_data[6:3] == 4'h0
    && o_rd_data[2:0] == $past(o_refresh_rate, 3) && o_rd_data[7] == $past(o_temperature_update_flag, 3))
    else $error("temperature read image wrong");
  rate_code_a: assert property (o_refresh_rate != 3'h4)
    else $error("reserved rate code shown");
  rd_wait_a: assert property (i_mrr_req && !i_mrw_req && !o_rd_busy && o_read_latency == 4'h3
    |=> o_rd_busy ##1 o_rd_busy ##1 !o_rd_busy && o_rd_valid)
    else $error("read wait window wrong");
endmodule // lmrb_checker

bind lmrb_top lmrb_checker chk (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_mrw_req(i_mrw_req),
  .i_mrr_req(i_mrr_req), .i_ma(i_ma), .i_op(i_op), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data),
  .o_rd_busy(o_rd_busy), .o_read_latency(o_read_latency), .o_write_latency(o_write_latency),
  .o_drive_strength(o_drive_strength), .o_refresh_rate(o_refresh_rate),
  .o_temperature_update_flag(o_temperature_update_flag));

/* File: sim/lmrb_ctl.sv */
// controller model issuing mode register commands
`timescale 1ns/1ns
module lmrb_ctl (
  // clock
  input  wire logic                 i_clk,
  // answers from the bank
  input  wire logic                 i_rd_valid,
  input  wire lmrb_pkg::lmrb_byte_t i_rd_data,
  input  wire lmrb_pkg::lmrb_rate_t i_rate,
  // commands
  output lmrb_pkg::lmrb_byte_t      o_ma,
  output lmrb_pkg::lmrb_byte_t      o_op,
  output logic                      o_mrw_req,
  output logic                      o_mrr_req,
  // refresh policy
  output logic [4:0]                o_refi_quarters,
  output logic [11:0]               o_core_extra_ps,
  output logic                      o_out_of_range
);
  import lmrb_pkg::*;
  // out-of-range codes fall back to the fastest refresh
  assign o_refi_quarters = i_rate == 3'h1 ? 5'h10 : i_rate == 3'h2 ? 5'h08 : i_rate == 3'h3 ? 5'h04 : 5'h01;
  assign o_core_extra_ps = i_rate == 3'h6 ? 12'h753 : 12'h000;
  assign o_out_of_range = i_rate == 3'h0 || i_rate == 3'h7;
  initial begin
    o_mrw_req = 1'b0;
    o_mrr_req = 1'b0;
    o_ma = 8'h00;
    o_op = 8'h00;
  end
  // idle address and data inverted so nothing leans on stale values
  task automatic mr_write(input lmrb_byte_t ma, input lmrb_byte_t op);
    @(posedge i_clk);
    #1;
    o_mrw_req = 1'b1;
    o_ma = ma;
    o_op = op;
    @(posedge i_clk);
    #1;
    o_mrw_req = 1'b0;
    o_ma = ~ma;
    o_op = ~op;
  endtask
  // lat stays 0 if no answer comes within 12 cycles
  task automatic mr_read(input lmrb_byte_t ma, output lmrb_byte_t data, output int lat);
    lat = 0;
    data = 8'h00;
    @(posedge i_clk);
    #1;
    o_mrr_req = 1'b1;
    o_ma = ma;
    for (int n = 1; n <= 12 && lat == 0; n++) begin
      @(posedge i_clk);
      #1;
      o_mrr_req = 1'b0;
      o_ma = ~ma;
      if (i_rd_valid === 1'b1) begin
        data = i_rd_data;
        lat = n;
      end
    end
  endtask
endmodule // lmrb_ctl

/* File: sim/lmrb_bench.sv */
// self-checking bench for the mode register bank
`timescale 1ns/1ns
`include "lmrb_map.svh"
module lmrb_bench;
  import lmrb_pkg::*;
  // identity values are arbitrary
  localparam lmrb_byte_t MK = 8'h3c;
  localparam lmrb_byte_t RV1 = 8'h41;
  localparam lmrb_byte_t RV2 = 8'h42;
  logic        clk;
  logic        rst;
  logic [7:0]  temp;
  logic        mrw;
  logic        mrr;
  lmrb_byte_t  ma;
  lmrb_byte_t  op;
  logic        rd_valid;
  lmrb_byte_t  rd_data;
  logic        rd_busy;
  logic [3:0]  rl;
  logic [2:0]  wl;
  logic [3:0]  drv;
  logic [11:0] ohm;
  lmrb_rate_t  rate;
  logic        flag;
  lmrb_byte_t  d;
  int          lat;
  int          n_fail = 0;
  int          checks = 0;
  logic [11:0] e_rl = 12'h003;
  logic [11:0] e_wl = 12'h001;
  logic [11:0] e_drv = 12'h002;
  logic [11:0] e_ohm = 12'h190;
  int          ohm_tab [16] = '{0, 343, 400, 480, 600, 0, 800, 1200, 0, 0, 0, 0, 0, 0, 0, 0};
  int          temps [7] = '{-40, 0, 30, 60, 90, 100, 120};
  int          rates [7] = '{0, 1, 2, 3, 5, 6, 7};
  lmrb_top #(.MAKER_ID(MK), .REV_ONE(RV1), .REV_TWO(RV2), .DENSITY(4'h6), .IO_WIDTH(2'h2)) dut (
    .i_clk(clk), .i_sys_rst(rst), .i_mrw_req(mrw), .i_mrr_req(mrr), .i_ma(ma), .i_op(op),
    .o_rd_valid(rd_valid), .o_rd_data(rd_data), .o_rd_busy(rd_busy), .i_die_temp(temp),
    .o_read_latency(rl), .o_write_latency(wl), .o_drive_strength(drv), .o_drive_ohm_tenths(ohm),
    .o_refresh_rate(rate), .o_temperature_update_flag(flag));
  lmrb_ctl ctl (.i_clk(clk), .i_rd_valid(rd_valid), .i_rd_data(rd_data), .i_rate(rate), .o_ma(ma),
    .o_op(op), .o_mrw_req(mrw), .o_mrr_req(mrr), .o_refi_quarters(), .o_core_extra_ps(), .o_out_of_range());
  task automatic cmp(input string what, input logic [11:0] exp, input logic [11:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic rd(input lmrb_byte_t a, input lmrb_byte_t exp);
    ctl.mr_read(a, d, lat);
    if (lat == 0) begin
      n_fail++;
      give_verdict();
    end
    cmp("read data", 12'(exp), 12'(d));
  endtask
  task automatic check_defaults;
    cmp("read latency", 12'h003, 12'(rl));
    cmp("write latency", 12'h001, 12'(wl));
    cmp("drive code", 12'h002, 12'(drv));
    cmp("drive ohms", 12'h190, ohm);
    cmp("update flag", 12'h000, 12'(flag));
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    temp = 8'h3c;
    repeat (12) @(posedge clk);
    #1;
    rst = 1'b0;
    check_defaults();
    for (int c = 0; c < 16; c++) begin
      ctl.mr_write(`LMRB_MA_LATENCY, 8'(c));
      if (c >= 1 && c <= 6) begin
        e_rl = 12'(c + 2);
        e_wl = c == 1 ? 12'h001 : c <= 3 ? 12'h002 : c == 4 ? 12'h003 : 12'h004;
      end
      cmp("read latency", e_rl, 12'(rl));
      cmp("write latency", e_wl, 12'(wl));
      rd(`LMRB_MA_MAKER, MK);
      cmp("read delay", e_rl, 12'(lat));
    end
    ctl.mr_write(`LMRB_MA_LATENCY, 8'h01);
    for (int c = 0; c < 16; c++) begin
      ctl.mr_write(`LMRB_MA_IODRIVE, {4'ha, 4'(c)});
      if (ohm_tab[c] != 0) begin
        e_drv = 12'(c);
        e_ohm = 12'(ohm_tab[c]);
      end
      cmp("drive code", e_drv, 12'(drv));
      cmp("drive ohms", e_ohm, ohm);
    end
    for (int i = 0; i < 2; i++) begin
      rd(`LMRB_MA_REV_ONE, RV1);
      rd(`LMRB_MA_REV_TWO, RV2);
      rd(`LMRB_MA_BASICCFG, 8'h9a);
      rd(`LMRB_MA_LATENCY, 8'h00);
      rd(8'h30, 8'h00);
      for (int a = 4; a <= 8; a++)
        ctl.mr_write(8'(a), 8'hff);
      cmp("read latency", 12'h003, 12'(rl));
    end
    for (int i = 0; i < 7; i++) begin
      temp = 8'(temps[i]);
      repeat (8) @(posedge clk);
      #1;
      cmp("refresh rate", 12'(rates[i]), 12'(rate));
      cmp("derate extra", rates[i] == 6 ? 12'h753 : 12'h000, ctl.o_core_extra_ps);
      cmp("out of range", 12'(rates[i] == 0 || rates[i] == 7), 12'(ctl.o_out_of_range));
      cmp("update flag", 12'h001, 12'(flag));
      ctl.mr_write(`LMRB_MA_TEMP, 8'h00);
      cmp("update flag", 12'h001, 12'(flag));
      rd(`LMRB_MA_TEMP, {1'b1, 4'h0, 3'(rates[i])});
      cmp("update flag", 12'h000, 12'(flag));
      rd(`LMRB_MA_TEMP, {1'b0, 4'h0, 3'(rates[i])});
    end
    ctl.mr_write(`LMRB_MA_LATENCY, 8'h06);
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    check_defaults();
    rd(`LMRB_MA_MAKER, MK);
    cmp("read delay", 12'h003, 12'(lat));
    give_verdict();
  end
endmodule // lmrb_bench
